/* logic/ttil_params.svh */
// Constants of the time tag and interrupt logic
`ifndef TTIL_PARAMS_SVH
`define TTIL_PARAMS_SVH

// Timing
`define TTIL_CLK_MHZ    125
`define TTIL_CLK_NS     8
`define TTIL_US_CYC     (1 * `TTIL_CLK_MHZ)
`define TTIL_PULSE_NS   500
`define TTIL_PULSE_CYC  ((`TTIL_PULSE_NS + `TTIL_CLK_NS - 1) / `TTIL_CLK_NS)
`define TTIL_PULSE_W    6
`define TTIL_RES_W      3
`define TTIL_RES_MAX    3'h5
`define TTIL_DIV_W      6

// Register byte offsets
`define TTIL_OFS_CTRL   5'h00
`define TTIL_OFS_CMD    5'h04
`define TTIL_OFS_TAG    5'h08
`define TTIL_OFS_MASK   5'h0C
`define TTIL_OFS_STAT   5'h10

// Widths and reset values
`define TTIL_CTRL_W     14
`define TTIL_CTRL_RST   14'h0000
`define TTIL_STAT_W     8
`define TTIL_ENG_IRQ_W  7
`define TTIL_MASK_RST   8'h00
`define TTIL_STAT_RST   8'h00
`define TTIL_TAG_RST    16'h0000
`define TTIL_TAG_MAX    16'hFFFF
`define TTIL_TAG_ONE    16'h0001
`define TTIL_STAMP_OFS  16'h0001

// Command register bits
`define TTIL_CMD_SWRST  0
`define TTIL_CMD_INTRST 1
`define TTIL_CMD_TAGRST 2
`define TTIL_CMD_TAGINC 3

// Status bit positions
`define TTIL_ST_ROLL    0
`define TTIL_ST_ENG0    1

`endif

/* logic/ttil_pkg.sv */
// Types of the time tag and interrupt logic
`default_nettype none
package ttil_pkg;

   typedef enum logic [1:0] {
      TTIL_INT_PULSE,
      TTIL_INT_SWCLR,
      TTIL_INT_RDCLR,
      TTIL_INT_RSV
   } ttil_int_mode_t;

   typedef struct packed {
      logic           svcReq;
      logic           enhanced;
      ttil_int_mode_t intMode;
      logic           autoSvcClr;
      logic           rollEn;
      logic           syncLoadEn;
      logic           syncClrEn;
      logic           swIncSel;
      logic           extClkSel;
      logic [2:0]     resSel;
      logic           clk12Mode;
   } ttil_ctrl_t;

   typedef struct packed {
      logic       msgEnd;
      logic       syncNoData;
      logic       syncWithData;
      logic       txVecDone;
      logic [6:0] engIrq;
   } ttil_eng_evt_t;

   typedef struct packed {
      logic        wrEn;
      logic [15:0] addr;
      logic [15:0] data;
   } ttil_stamp_t;

endpackage
`default_nettype wire

/* logic/ttil_tick.sv */
// Time tag tick generator: internal prescaler or external tag clock
`timescale 1ns/10ps
`default_nettype none
`include "ttil_params.svh"

module ttil_tick (
   input  wire logic                   clk,
   input  wire logic                   reset_n,
   input  wire logic                   clear,
   input  wire logic [`TTIL_RES_W-1:0] resSel,
   input  wire logic                   extSel,
   input  wire logic                   tagClkPin,
   output logic                        tick
);
   localparam int USC = `TTIL_US_CYC;

   logic [7:0]             usCnt_r;
   logic                   usPulse;
   logic [`TTIL_DIV_W-1:0] resCnt_r;
   logic [`TTIL_DIV_W-1:0] resLim;
   logic [`TTIL_RES_W-1:0] resEff;
   logic                   s1_r, s2_r, s3_r, lvl_r;
   logic                   extEdge;

   assign usPulse = (usCnt_r == 8'(USC - 1));
   assign resEff  = (resSel > `TTIL_RES_MAX) ? `TTIL_RES_MAX : resSel;
   // 2 << n microseconds per count, n = 0..5
   assign resLim  = `TTIL_DIV_W'((7'h02 << resEff) - 7'h01);

   // Time base from clk, independent of the decoder clock mode
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         usCnt_r <= 8'h00;
      end else if (clear || usPulse) begin
         usCnt_r <= 8'h00;
      end else begin
         usCnt_r <= usCnt_r + 8'h01;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         resCnt_r <= 6'h00;
      end else if (clear) begin
         resCnt_r <= 6'h00;
      end else if (usPulse) begin
         resCnt_r <= (resCnt_r >= resLim) ? 6'h00 : resCnt_r + 6'h01;
      end
   end

   // Pin synchroniser; first stage feeds only the second
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s1_r  <= 1'b0;
         s2_r  <= 1'b0;
         s3_r  <= 1'b0;
         lvl_r <= 1'b0;
      end else begin
         s1_r <= tagClkPin;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r) begin
            lvl_r <= s3_r;
         end
      end
   end

   assign extEdge = (s2_r == s3_r) && s3_r && !lvl_r;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tick <= 1'b0;
      end else if (clear) begin
         tick <= 1'b0;
      end else begin
         tick <= extSel ? extEdge : (usPulse && (resCnt_r >= resLim));
      end
   end

   a_us_period: assert property (
      @(posedge clk) disable iff (!reset_n || clear)
      usPulse |-> ##USC usPulse)
      else $error("microsecond base period wrong");

   a_ext_edge: assert property (
      @(posedge clk) disable iff (!reset_n)
      extSel && !clear && !$past(s3_r) && s3_r && s2_r && !lvl_r |=> tick)
      else $error("external tag clock edge missed");

endmodule // ttil_tick
`default_nettype wire

/* logic/ttil_core.sv */
// Time tag counter, decoder clock mode and interrupt logic with Avalon slave
`timescale 1ns/10ps
`default_nettype none
`include "ttil_params.svh"

// Function
// - Hardware reset and software reset select 16 MHz sampling mode
// - Software can select 12 MHz clock mode
// - 12 MHz mode samples on both edges
// - 16-bit readable writable tag, selectable resolution
// - Tag may advance from external clock
// - Software may increment tag for self-test
// - Tag value stamped into second descriptor word
// - Sync without data clears tag when enabled
// - Sync with data loads tag when enabled
// - Rollover sets status bit, may interrupt
// - Vector word response clears service request
// - Interrupt pin: pulse, software-clear, read-clear level
// - Standard mode: status set only when masked-in
// - Enhanced mode: status set regardless of mask
// - Pin request only for masked-in conditions
module ttil_core (
   input  wire logic                  clk,
   input  wire logic                  reset_n,
   input  wire logic [4:0]            avs_address,
   input  wire logic                  avs_read,
   input  wire logic                  avs_write,
   input  wire logic [31:0]           avs_writedata,
   input  wire logic [3:0]            avs_byteenable,
   output logic [31:0]                avs_readdata,
   output logic                       avs_waitrequest,
   input  wire ttil_pkg::ttil_eng_evt_t engEvt,
   input  wire logic [15:0]           syncWord,
   input  wire logic [15:0]           descBase,
   input  wire logic                  tagClkPin,
   output ttil_pkg::ttil_stamp_t      stampWr,
   output logic                       decDualEdge,
   output logic                       svcReqBit,
   output logic                       intOut_n,
   output logic                       irq
);
   localparam int PULSE_CYC = `TTIL_PULSE_CYC;

   ttil_pkg::ttil_ctrl_t         ctrl_r;
   logic [15:0]                  tag_r;
   logic [`TTIL_STAT_W-1:0]      mask_r;
   logic [`TTIL_STAT_W-1:0]      status_r;
   logic [`TTIL_STAT_W-1:0]      snap_r;
   logic                         ackR;
   logic                         req;
   logic                         wrAcc;
   logic                         rdAcc;
   logic [15:0]                  ctrlWr;
   logic [15:0]                  tagWr;
   logic [15:0]                  maskWr;
   logic                         cmdWr;
   logic                         swRst;
   logic                         intRst;
   logic                         tagRst;
   logic                         cmdInc;
   logic                         tagWrEn;
   logic                         syncClr;
   logic                         syncLd;
   logic                         tick;
   logic                         incEn;
   logic                         incTake;
   logic                         rollEv;
   logic [`TTIL_STAT_W-1:0]      evtVec;
   logic [`TTIL_STAT_W-1:0]      setV;
   logic                         newReq;
   logic                         statRdClr;
   logic [`TTIL_PULSE_W-1:0]     pulseCnt_r;
   logic                         intLatch_r;
   logic                         intActive;

   function automatic logic [15:0] beMerge(input logic [15:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be);
      beMerge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
   endfunction

   // Avalon slave: one wait state, answer on the second edge
   assign req             = avs_read || avs_write;
   assign avs_waitrequest = req && !ackR;
   assign wrAcc           = avs_write && ackR;
   assign rdAcc           = avs_read && ackR;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ackR <= 1'b0;
      end else begin
         ackR <= req && !ackR;
      end
   end

   // Read data captured on the first edge and held through the answer
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         avs_readdata <= 32'h0000_0000;
         snap_r       <= `TTIL_STAT_RST;
      end else if (avs_read && !ackR) begin
         snap_r <= `TTIL_STAT_RST;
         case (avs_address)
            `TTIL_OFS_CTRL: avs_readdata <= 32'(ctrl_r);
            `TTIL_OFS_TAG:  avs_readdata <= 32'(tag_r);
            `TTIL_OFS_MASK: avs_readdata <= 32'(mask_r);
            `TTIL_OFS_STAT: begin
               avs_readdata <= 32'(status_r);
               snap_r       <= status_r;
            end
            default:        avs_readdata <= 32'h0000_0000;
         endcase
      end
   end

   assign ctrlWr  = beMerge(16'(ctrl_r), avs_writedata, avs_byteenable);
   assign tagWr   = beMerge(tag_r, avs_writedata, avs_byteenable);
   assign maskWr  = beMerge(16'(mask_r), avs_writedata, avs_byteenable);
   assign cmdWr   = wrAcc && (avs_address == `TTIL_OFS_CMD)
                    && avs_byteenable[0];
   assign swRst   = cmdWr && avs_writedata[`TTIL_CMD_SWRST];
   assign intRst  = cmdWr && avs_writedata[`TTIL_CMD_INTRST];
   assign tagRst  = cmdWr && avs_writedata[`TTIL_CMD_TAGRST];
   assign cmdInc  = cmdWr && avs_writedata[`TTIL_CMD_TAGINC];
   assign tagWrEn = wrAcc && (avs_address == `TTIL_OFS_TAG);
   assign statRdClr = rdAcc && (avs_address == `TTIL_OFS_STAT);

   // Configuration; software reset returns to the 16 MHz mode
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_r <= ttil_pkg::ttil_ctrl_t'(`TTIL_CTRL_RST);
      end else if (swRst) begin
         ctrl_r <= ttil_pkg::ttil_ctrl_t'(`TTIL_CTRL_RST);
      end else if (wrAcc && (avs_address == `TTIL_OFS_CTRL)) begin
         ctrl_r <= ttil_pkg::ttil_ctrl_t'(ctrlWr[`TTIL_CTRL_W-1:0]);
      end else if (engEvt.txVecDone && ctrl_r.autoSvcClr) begin
         ctrl_r.svcReq <= 1'b0;
      end
   end

   assign decDualEdge = ctrl_r.clk12Mode;
   assign svcReqBit   = ctrl_r.svcReq;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mask_r <= `TTIL_MASK_RST;
      end else if (swRst) begin
         mask_r <= `TTIL_MASK_RST;
      end else if (wrAcc && (avs_address == `TTIL_OFS_MASK)) begin
         mask_r <= maskWr[`TTIL_STAT_W-1:0];
      end
   end

   ttil_tick u_tick (
      .clk       (clk),
      .reset_n   (reset_n),
      .clear     (swRst),
      .resSel    (ctrl_r.resSel),
      .extSel    (ctrl_r.extClkSel),
      .tagClkPin (tagClkPin),
      .tick      (tick)
   );

   // Time tag counter; sync commands take priority over counting
   assign syncClr = engEvt.syncNoData && ctrl_r.syncClrEn;
   assign syncLd  = engEvt.syncWithData && ctrl_r.syncLoadEn;
   assign incEn   = ctrl_r.swIncSel ? cmdInc : tick;
   assign incTake = incEn && !swRst && !tagRst && !tagWrEn
                    && !syncClr && !syncLd;
   assign rollEv  = incTake && (tag_r == `TTIL_TAG_MAX);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tag_r <= `TTIL_TAG_RST;
      end else if (swRst || tagRst) begin
         tag_r <= `TTIL_TAG_RST;
      end else if (tagWrEn) begin
         tag_r <= tagWr;
      end else if (syncClr) begin
         tag_r <= `TTIL_TAG_RST;
      end else if (syncLd) begin
         tag_r <= syncWord;
      end else if (incTake) begin
         tag_r <= tag_r + `TTIL_TAG_ONE;
      end
   end

   // Tag stamp toward the descriptor stack
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         stampWr <= '0;
      end else begin
         stampWr.wrEn <= engEvt.msgEnd;
         stampWr.addr <= descBase + `TTIL_STAMP_OFS;
         stampWr.data <= tag_r;
      end
   end

   // Interrupt status; a new event wins over a read clear
   assign evtVec = {engEvt.engIrq, rollEv && ctrl_r.rollEn};
   assign setV   = evtVec & (ctrl_r.enhanced ? {`TTIL_STAT_W{1'b1}}
                                             : mask_r);
   assign newReq = |(evtVec & mask_r);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         status_r <= `TTIL_STAT_RST;
      end else if (swRst) begin
         status_r <= `TTIL_STAT_RST;
      end else if (statRdClr) begin
         status_r <= (status_r & ~snap_r) | setV;
      end else begin
         status_r <= status_r | setV;
      end
   end

   assign irq = |(status_r & mask_r);

   // Pin modes
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pulseCnt_r <= '0;
      end else if (newReq) begin
         pulseCnt_r <= `TTIL_PULSE_W'(PULSE_CYC);
      end else if (pulseCnt_r != '0) begin
         pulseCnt_r <= pulseCnt_r - `TTIL_PULSE_W'(1);
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         intLatch_r <= 1'b0;
      end else if (newReq) begin
         intLatch_r <= 1'b1;
      end else if (intRst || swRst) begin
         intLatch_r <= 1'b0;
      end
   end

   always_comb begin
      case (ctrl_r.intMode)
         ttil_pkg::TTIL_INT_PULSE: intActive = (pulseCnt_r != '0);
         ttil_pkg::TTIL_INT_SWCLR: intActive = intLatch_r;
         ttil_pkg::TTIL_INT_RDCLR: intActive = irq;
         default:                  intActive = irq;
      endcase
   end

   // Registered so the pin never glitches while modes change
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         intOut_n <= 1'b1;
      end else begin
         intOut_n <= !intActive;
      end
   end

   a_soft_reset: assert property (
      @(posedge clk) disable iff (!reset_n)
      swRst |=> !decDualEdge && (tag_r == `TTIL_TAG_RST))
      else $error("software reset left 12 MHz mode or tag");

   a_mode_write: assert property (
      @(posedge clk) disable iff (!reset_n)
      wrAcc && (avs_address == `TTIL_OFS_CTRL) && avs_byteenable[0]
      && !swRst |=> decDualEdge == $past(avs_writedata[0]))
      else $error("clock mode not taken from write");

   a_sw_inc: assert property (
      @(posedge clk) disable iff (!reset_n)
      ctrl_r.swIncSel && incTake |=> tag_r == $past(tag_r) + `TTIL_TAG_ONE)
      else $error("software increment failed");

   a_stamp_word: assert property (
      @(posedge clk) disable iff (!reset_n)
      engEvt.msgEnd |=> stampWr.wrEn && (stampWr.data == $past(tag_r))
      && (stampWr.addr == $past(descBase) + `TTIL_STAMP_OFS))
      else $error("time stamp word not written");

   a_sync_clear: assert property (
      @(posedge clk) disable iff (!reset_n)
      syncClr && !tagWrEn |=> tag_r == `TTIL_TAG_RST)
      else $error("sync without data did not clear tag");

   a_sync_load: assert property (
      @(posedge clk) disable iff (!reset_n)
      syncLd && !syncClr && !tagWrEn && !swRst && !tagRst
      |=> tag_r == $past(syncWord))
      else $error("sync with data did not load tag");

   a_roll_flag: assert property (
      @(posedge clk) disable iff (!reset_n)
      incTake && (tag_r == `TTIL_TAG_MAX) && ctrl_r.rollEn
      && (ctrl_r.enhanced || mask_r[`TTIL_ST_ROLL])
      |=> status_r[`TTIL_ST_ROLL] && (tag_r == `TTIL_TAG_RST))
      else $error("rollover flag not set");

   a_svc_clear: assert property (
      @(posedge clk) disable iff (!reset_n)
      engEvt.txVecDone && ctrl_r.autoSvcClr && !wrAcc |=> !svcReqBit)
      else $error("service request not cleared");

   a_int_pulse: assert property (
      @(posedge clk) disable iff (!reset_n)
      newReq && ctrl_r.intMode == ttil_pkg::TTIL_INT_PULSE && !wrAcc
      |=> ##1 !intOut_n)
      else $error("interrupt pulse missing");

   a_std_gate: assert property (
      @(posedge clk) disable iff (!reset_n)
      !ctrl_r.enhanced |=>
      ((status_r & ~$past(status_r) & ~$past(mask_r)) == `TTIL_STAT_RST))
      else $error("masked status bit set in standard mode");

   a_enh_set: assert property (
      @(posedge clk) disable iff (!reset_n)
      ctrl_r.enhanced && !swRst
      |=> ((status_r & $past(evtVec)) == $past(evtVec)))
      else $error("enhanced mode lost a status event");

   a_irq_gate: assert property (
      @(posedge clk) disable iff (!reset_n)
      ((evtVec & mask_r) == `TTIL_STAT_RST) && (pulseCnt_r == '0)
      |=> (pulseCnt_r == '0))
      else $error("masked condition raised interrupt pulse");

   a_latch_gate: assert property (
      @(posedge clk) disable iff (!reset_n)
      ((evtVec & mask_r) == `TTIL_STAT_RST) && !intLatch_r |=> !intLatch_r)
      else $error("masked condition set interrupt latch");

   a_pulse_load: assert property (
      @(posedge clk) disable iff (!reset_n)
      newReq |=> pulseCnt_r == `TTIL_PULSE_W'(PULSE_CYC))
      else $error("interrupt pulse length not loaded");

   a_read_clear: assert property (
      @(posedge clk) disable iff (!reset_n)
      statRdClr && (setV == `TTIL_STAT_RST) && !swRst
      |=> ((status_r & $past(snap_r)) == `TTIL_STAT_RST))
      else $error("status read did not clear captured bits");

endmodule // ttil_core
`default_nettype wire

/* tb/ttil_eng_model.sv */
// Protocol engine stand-in: event pulses and external tag clock
`timescale 1ns/10ps
`default_nettype none
module ttil_eng_model (
   input  wire logic               clk,
   output ttil_pkg::ttil_eng_evt_t engEvt,
   output logic [15:0]             syncWord,
   output logic [15:0]             descBase,
   output logic                    tagClkPin
);
   initial begin
      engEvt = '0;
      syncWord = 16'hA5A5;
      descBase = 16'h5A5A;
      tagClkPin = 1'h0;
   end

   // Data words hold only with the pulse, inverted afterwards
   task automatic send(input logic [10:0] e, input logic [15:0] w,
                       input logic [15:0] d);
      @(posedge clk);
      engEvt <= ttil_pkg::ttil_eng_evt_t'(e);
      syncWord <= w;
      descBase <= d;
      @(posedge clk);
      engEvt <= '0;
      syncWord <= ~w;
      descBase <= ~d;
   endtask

   // Pin stands low outside bursts
   task automatic tagClk(input int n);
      repeat (n) begin
         repeat (5) @(posedge clk);
         tagClkPin <= 1'h1;
         repeat (5) @(posedge clk);
         tagClkPin <= 1'h0;
      end
   endtask
endmodule // ttil_eng_model
`default_nettype wire

/* tb/time_tag_and_interrupt_logic_tb_top.sv */
// Self-checking bench of the time tag and interrupt logic
`timescale 1ns/10ps
`default_nettype none
module time_tag_and_interrupt_logic_tb_top;
   localparam logic [4:0] A_CT = 5'h00;
   localparam logic [4:0] A_CM = 5'h04;
   localparam logic [4:0] A_TG = 5'h08;
   localparam logic [4:0] A_MK = 5'h0C;
   localparam logic [4:0] A_ST = 5'h10;
   localparam int         RES[4] = '{0, 1, 2, 5};

   logic                    clk = 1'h0;
   logic                    reset_n = 1'h0;
   logic [4:0]              avsAddress = 5'h00;
   logic                    avsRead = 1'h0;
   logic                    avsWrite = 1'h0;
   logic [31:0]             avsWritedata = 32'h0;
   logic [3:0]              avsByteenable = 4'hF;
   logic [31:0]             avsReaddata;
   logic                    avsWaitrequest;
   ttil_pkg::ttil_eng_evt_t engEvt;
   logic [15:0]             syncWord;
   logic [15:0]             descBase;
   logic                    tagClkPin;
   ttil_pkg::ttil_stamp_t   stampWr;
   logic                    decDualEdge;
   logic                    svcReqBit;
   logic                    intOut_n;
   logic                    irq;
   logic [3:0]              beSel = 4'hF;
   logic [15:0]             lfsr = 16'h004F;
   logic [31:0]             expQ[$];
   logic [31:0]             mskQ[$];
   logic [31:0]             stmQ[$];
   int                      failures = 0;
   int                      nTests = 0;
   int                      cyc = 0;

   always #4 clk = ~clk;

   ttil_core i_dut (
      .clk(clk), .reset_n(reset_n), .avs_address(avsAddress),
      .avs_read(avsRead), .avs_write(avsWrite),
      .avs_writedata(avsWritedata), .avs_byteenable(avsByteenable),
      .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest),
      .engEvt(engEvt), .syncWord(syncWord), .descBase(descBase),
      .tagClkPin(tagClkPin), .stampWr(stampWr),
      .decDualEdge(decDualEdge), .svcReqBit(svcReqBit),
      .intOut_n(intOut_n), .irq(irq)
   );

   ttil_eng_model i_eng (
      .clk(clk), .engEvt(engEvt), .syncWord(syncWord),
      .descBase(descBase), .tagClkPin(tagClkPin)
   );

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      nTests++;
      if (seen !== exp) begin
         failures++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic chk1(input logic seen, input logic exp);
      check({31'h0, seen}, {31'h0, exp});
   endtask

   task automatic end_sim;
      $display("comparisons=%0d mismatches=%0d", nTests, failures);
      if (failures == 0 && nTests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   function automatic logic [15:0] nextRand(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   // Request held until waitrequest is seen low at a rising edge
   task automatic bus(input logic rw, input logic [4:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      avsAddress <= a;
      avsWritedata <= d;
      avsByteenable <= beSel;
      avsWrite <= rw;
      avsRead <= ~rw;
      do begin
         @(posedge clk);
         n++;
      end while (avsWaitrequest && n < 50);
      chk1(avsWaitrequest, 1'h0);
      avsRead <= 1'h0;
      avsWrite <= 1'h0;
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      bus(1'h1, a, d);
   endtask

   task automatic rd(input logic [4:0] a, input logic [31:0] e);
      expQ.push_back(e);
      mskQ.push_back(32'hFFFFFFFF);
      bus(1'h0, a, 32'h0);
   endtask

   // Result watcher and hang guard
   always @(posedge clk) begin
      cyc++;
      if (avsRead && !avsWaitrequest)
         check(avsReaddata & mskQ.pop_front(), expQ.pop_front());
      if (stampWr.wrEn === 1'h1)
         check({stampWr.addr, stampWr.data}, stmQ.pop_front());
      if (cyc > 50000) begin
         failures++;
         end_sim();
      end
   end

   initial begin
      repeat (5) @(posedge clk);
      reset_n <= 1'h1;
      chk1(decDualEdge, 1'h0);
      rd(A_CT, 32'h0);
      rd(A_TG, 32'h0);
      rd(A_MK, 32'h0);
      rd(A_ST, 32'h0);
      wr(5'h14, 32'hFFFF);
      rd(5'h14, 32'h0);
      wr(A_CT, 32'h1);
      rd(A_CT, 32'h1);
      chk1(decDualEdge, 1'h1);
      wr(A_CM, 32'h1);
      rd(A_CT, 32'h0);
      chk1(decDualEdge, 1'h0);
      // Software increment select keeps the tag frozen below
      lfsr = nextRand(lfsr);
      wr(A_CT, 32'h30);
      wr(A_TG, {16'h0, lfsr});
      rd(A_TG, {16'h0, lfsr});
      wr(A_CM, 32'h8);
      rd(A_TG, {16'h0, lfsr + 16'h1});
      beSel = 4'h2;
      wr(A_TG, 32'h0000ABCD);
      beSel = 4'hF;
      rd(A_TG, {16'h0, 8'hAB, lfsr[7:0] + 8'h1});
      lfsr = nextRand(lfsr);
      wr(A_TG, {16'h0, lfsr});
      stmQ.push_back({lfsr + 16'h1, lfsr});
      i_eng.send(11'h400, 16'h0, lfsr);
      repeat (3) @(posedge clk);
      check(stmQ.size(), 32'h0);
      i_eng.send(11'h200, 16'h0, 16'h0);
      rd(A_TG, {16'h0, lfsr});
      wr(A_CT, 32'h70);
      i_eng.send(11'h200, 16'h0, 16'h0);
      rd(A_TG, 32'h0);
      lfsr = nextRand(lfsr);
      wr(A_CT, 32'hB0);
      i_eng.send(11'h100, lfsr, 16'h0);
      rd(A_TG, {16'h0, lfsr});
      // Rollover with software-cleared level
      wr(A_MK, 32'h1);
      wr(A_CT, 32'h530);
      wr(A_TG, 32'hFFFF);
      wr(A_CM, 32'h8);
      repeat (3) @(posedge clk);
      chk1(irq, 1'h1);
      chk1(intOut_n, 1'h0);
      rd(A_ST, 32'h1);
      rd(A_ST, 32'h0);
      rd(A_TG, 32'h0);
      chk1(intOut_n, 1'h0);
      wr(A_CM, 32'h2);
      repeat (3) @(posedge clk);
      chk1(intOut_n, 1'h1);
      // Read-cleared level
      wr(A_MK, 32'h6);
      wr(A_CT, 32'h830);
      i_eng.send(11'h001, 16'h0, 16'h0);
      repeat (3) @(posedge clk);
      chk1(intOut_n, 1'h0);
      rd(A_ST, 32'h2);
      repeat (3) @(posedge clk);
      chk1(intOut_n, 1'h1);
      // Pulse output ends on its own
      wr(A_CT, 32'h30);
      i_eng.send(11'h002, 16'h0, 16'h0);
      repeat (3) @(posedge clk);
      chk1(intOut_n, 1'h0);
      repeat (55) @(posedge clk);
      chk1(intOut_n, 1'h0);
      repeat (15) @(posedge clk);
      chk1(intOut_n, 1'h1);
      rd(A_ST, 32'h4);
      // Masked-out condition, standard then enhanced
      i_eng.send(11'h004, 16'h0, 16'h0);
      rd(A_ST, 32'h0);
      wr(A_CT, 32'h1030);
      i_eng.send(11'h004, 16'h0, 16'h0);
      repeat (3) @(posedge clk);
      chk1(irq, 1'h0);
      chk1(intOut_n, 1'h1);
      rd(A_ST, 32'h8);
      wr(A_CT, 32'h2230);
      repeat (3) @(posedge clk);
      chk1(svcReqBit, 1'h1);
      i_eng.send(11'h080, 16'h0, 16'h0);
      repeat (3) @(posedge clk);
      chk1(svcReqBit, 1'h0);
      rd(A_CT, 32'h0230);
      wr(A_CT, 32'h10);
      wr(A_TG, 32'h0);
      i_eng.tagClk(5);
      repeat (8) @(posedge clk);
      rd(A_TG, 32'h5);
      // Four ticks at resolutions 0, 1, 2 and 5, both clock modes
      foreach (RES[i]) begin
         wr(A_CM, 32'h1);
         wr(A_CT, 32'((RES[i] << 1) | (i % 2)));
         wr(A_TG, 32'h0);
         repeat (4 * (250 << RES[i])) @(posedge clk);
         rd(A_TG, 32'h4);
      end
      end_sim();
   end
endmodule // time_tag_and_interrupt_logic_tb_top
`default_nettype wire
